// ===== design/wecr_pkg.sv
// Package with the address map, field layout and reset values of the waveform engine registers.
package wecr_pkg;

  localparam int NUM_EP    = 3;
  localparam int NUM_READY = 6;

  // Endpoint order in every per-endpoint vector: index 0 is endpoint 4, 1 is 6, 2 is 8.
  localparam logic [NUM_EP-1:0][15:0] FLAG_SEL_ADDR = {16'he6ea, 16'he6e2, 16'he6da};
  localparam logic [NUM_EP-1:0][15:0] STOP_ADDR     = {16'he6eb, 16'he6e3, 16'he6db};
  localparam logic [NUM_EP-1:0][15:0] TRIG_ADDR     = {16'he6ec, 16'he6e4, 16'he6dc};

  localparam logic [15:0] SINGLE_DATA_HIGH_ADDR        = 16'he6f0;
  localparam logic [15:0] SINGLE_DATA_LOW_TRIGGER_ADDR = 16'he6f1;
  localparam logic [15:0] SINGLE_DATA_LOW_QUIET_ADDR   = 16'he6f2;
  localparam logic [15:0] READY_INPUT_CONFIG_ADDR      = 16'he6f3;
  localparam logic [15:0] READY_PIN_STATUS_ADDR        = 16'he6f4;
  localparam logic [15:0] WAVEFORM_ABORT_ADDR          = 16'he6f5;
  localparam logic [15:0] NO_ADDR                      = 16'h0000;

  // Special function register mirrors.
  localparam logic [7:0] SFR_TRIGGER_ADDR                 = 8'hbb;
  localparam logic [7:0] SFR_SINGLE_DATA_HIGH_ADDR        = 8'hbd;
  localparam logic [7:0] SFR_SINGLE_DATA_LOW_TRIGGER_ADDR = 8'hbe;
  localparam logic [7:0] SFR_SINGLE_DATA_LOW_QUIET_ADDR   = 8'hbf;

  // Endpoint code carried in bits 1:0 of a mirrored trigger write.
  localparam logic [NUM_EP-1:0][1:0] SFR_TRIG_CODE = {2'h3, 2'h2, 2'h1};
  localparam int                     SFR_TRIG_LSB  = 0;

  localparam logic [1:0] FLAG_SEL_PROG  = 2'h0;
  localparam logic [1:0] FLAG_SEL_EMPTY = 2'h1;
  localparam logic [1:0] FLAG_SEL_FULL  = 2'h2;
  localparam int         FLAG_SEL_LSB   = 0;
  localparam int         STOP_BIT       = 0;

  localparam int FIRMWARE_READY_BIT      = 7;
  localparam int READY_SYNC_SELECT_BIT   = 6;
  localparam int COUNT_EXPIRY_READY5_BIT = 5;
  localparam int READY_CFG_LSB           = 5;

  localparam logic [1:0] FLAG_SEL_RESET    = 2'h0;
  localparam logic [2:0] READY_CFG_RESET   = 3'h0;
  localparam logic [7:0] DATA_RESET        = 8'h00;
  localparam logic [7:0] WRITE_ONLY_READ   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

endpackage

// ===== design/wecr_ready_sync.sv
// Ready input conditioning: a two-flop synchroniser or a single synchronous sample per pin.
`timescale 1ns/100ps
module wecr_ready_sync
  import wecr_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rstn,
  input  wire logic [NUM_READY-1:0] i_ready_pins,
  input  wire logic                 i_sync_select,
  output logic      [NUM_READY-1:0] o_ready
);

  logic [NUM_READY-1:0] meta;
  logic [NUM_READY-1:0] stable;
  logic [NUM_READY-1:0] sample;
  logic [NUM_READY-1:0] next_meta;
  logic [NUM_READY-1:0] next_stable;
  logic [NUM_READY-1:0] next_sample;

  genvar b;
  generate
    for (b = 0; b < NUM_READY; b++)
    begin : g_pin
      always_comb
      begin
        next_meta[b]   = i_ready_pins[b];
        next_stable[b] = meta[b];
        next_sample[b] = i_ready_pins[b];
      end

      always_ff @(posedge i_core_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          meta[b]   <= 1'b0;
          stable[b] <= 1'b0;
          sample[b] <= 1'b0;
        end
        else
        begin
          meta[b]   <= next_meta[b];
          stable[b] <= next_stable[b];
          sample[b] <= next_sample[b];
        end
      end

      // Synchronous mode trusts the pin to meet setup, so it costs one cycle only.
      assign o_ready[b] = i_sync_select ? sample[b] : stable[b];
    end
  endgenerate

endmodule

// ===== design/wecr_regs.sv
// Waveform engine control and status registers with their data-space and SFR-space access.
// Functional notes
// - Flag select picks programmable, empty or full flag.
// - Flag select: bits 1:0 RW, others zero.
// - Stop bit ends transaction on selected flag.
// - Stop bit overrides the transaction count.
// - Any data-space trigger write starts endpoint transactions.
// - High data byte used only on wide bus.
// - Low-trigger access moves byte, starts single transfer.
// - Quiet low register reads byte, no transfer.
// - Single data registers mirrored in SFR space.
// - Firmware ready bit acts as ready input.
// - Sync select: direct sample or two flops.
// - Ready config bits 7:5 RW, rest zero.
// - Ready status shows six pins, top zero.
// - Any abort write returns engine to idle.
`timescale 1ns/100ps
module wecr_regs
(
  input  wire logic                           i_core_clk,
  input  wire logic                           i_rstn,
  input  wire logic [15:0]                    i_xaddr,
  input  wire logic                           i_xwr,
  input  wire logic                           i_xrd,
  input  wire logic [7:0]                     i_xwdata,
  output logic      [7:0]                     o_xrdata,
  input  wire logic [7:0]                     i_sfr_addr,
  input  wire logic                           i_sfr_wr,
  input  wire logic                           i_sfr_rd,
  input  wire logic [7:0]                     i_sfr_wdata,
  output logic      [7:0]                     o_sfr_rdata,
  input  wire logic [wecr_pkg::NUM_EP-1:0]    i_prog_flag,
  input  wire logic [wecr_pkg::NUM_EP-1:0]    i_empty_flag,
  input  wire logic [wecr_pkg::NUM_EP-1:0]    i_full_flag,
  input  wire logic                           i_wide_bus,
  input  wire logic                           i_capture_valid,
  input  wire logic [15:0]                    i_capture_data,
  input  wire logic [wecr_pkg::NUM_READY-1:0] i_ready_inputs,
  output logic      [wecr_pkg::NUM_EP-1:0]    o_watched_flag,
  output logic      [wecr_pkg::NUM_EP-1:0]    o_flag_stop,
  output logic      [wecr_pkg::NUM_EP-1:0]    o_count_override,
  output logic      [wecr_pkg::NUM_EP-1:0]    o_ep_start,
  output logic                                o_single_write_start,
  output logic                                o_single_read_start,
  output logic      [15:0]                    o_single_wdata,
  output logic                                o_abort,
  output logic      [wecr_pkg::NUM_READY:0]   o_ready_terms,
  output logic                                o_ready_sync_select,
  output logic                                o_count_expiry_ready5
);
  import wecr_pkg::*;

  logic [NUM_EP-1:0][1:0]   flag_sel;
  logic [NUM_EP-1:0][1:0]   next_flag_sel;
  logic [NUM_EP-1:0]        stop;
  logic [NUM_EP-1:0]        next_stop;
  logic [NUM_EP-1:0]        selected_flag;
  logic [NUM_EP-1:0]        next_watched_flag;
  logic [NUM_EP-1:0]        next_flag_stop;
  logic [NUM_EP-1:0]        next_ep_start;
  logic [7:0]               data_high;
  logic [7:0]               data_low;
  logic [7:0]               next_data_high;
  logic [7:0]               next_data_low;
  logic                     next_single_write_start;
  logic                     next_single_read_start;
  logic [15:0]              next_single_wdata;
  logic [2:0]               ready_cfg;
  logic [2:0]               next_ready_cfg;
  logic                     next_abort;
  logic [NUM_READY-1:0]     ready_synced;
  logic [NUM_READY:0]       next_ready_terms;
  logic [7:0]               next_xrdata;
  logic [7:0]               next_sfr_rdata;
  logic [15:0]              sfr_equiv;

  // Mirrored single data SFR locations are handled as their data-space twins.
  always_comb
  begin
    case (i_sfr_addr)
      SFR_SINGLE_DATA_HIGH_ADDR:        sfr_equiv = SINGLE_DATA_HIGH_ADDR;
      SFR_SINGLE_DATA_LOW_TRIGGER_ADDR: sfr_equiv = SINGLE_DATA_LOW_TRIGGER_ADDR;
      SFR_SINGLE_DATA_LOW_QUIET_ADDR:   sfr_equiv = SINGLE_DATA_LOW_QUIET_ADDR;
      default:                          sfr_equiv = NO_ADDR;
    endcase
  end

  function automatic logic wr_hit(input logic [15:0] a);
    wr_hit = (i_xwr && i_xaddr == a) || (i_sfr_wr && sfr_equiv == a);
  endfunction

  function automatic logic rd_hit(input logic [15:0] a);
    rd_hit = (i_xrd && i_xaddr == a) || (i_sfr_rd && sfr_equiv == a);
  endfunction

  // Data-space write data wins when both buses write the same register together.
  function automatic logic [7:0] wr_data(input logic [15:0] a);
    wr_data = (i_xwr && i_xaddr == a) ? i_xwdata : i_sfr_wdata;
  endfunction

  function automatic logic [7:0] read_value(input logic [15:0] a);
    read_value = UNMAPPED_READ;
    for (int e = 0; e < NUM_EP; e++)
    begin
      if (a == FLAG_SEL_ADDR[e])
        read_value = {6'h00, flag_sel[e]};
      if (a == STOP_ADDR[e])
        read_value = {7'h00, stop[e]};
      if (a == TRIG_ADDR[e])
        read_value = WRITE_ONLY_READ;
    end
    case (a)
      SINGLE_DATA_HIGH_ADDR:        read_value = data_high;
      SINGLE_DATA_LOW_TRIGGER_ADDR: read_value = data_low;
      SINGLE_DATA_LOW_QUIET_ADDR:   read_value = data_low;
      READY_INPUT_CONFIG_ADDR:      read_value = {ready_cfg, 5'h00};
      READY_PIN_STATUS_ADDR:        read_value = {2'h0, ready_synced};
      WAVEFORM_ABORT_ADDR:          read_value = WRITE_ONLY_READ;
      default:                      read_value = read_value;
    endcase
  endfunction

  genvar e;
  generate
    for (e = 0; e < NUM_EP; e++)
    begin : g_ep
      always_comb
      begin
        next_flag_sel[e] = flag_sel[e];
        next_stop[e]     = stop[e];
        if (i_xwr && i_xaddr == FLAG_SEL_ADDR[e])
          next_flag_sel[e] = i_xwdata[FLAG_SEL_LSB +: 2];
        if (i_xwr && i_xaddr == STOP_ADDR[e])
          next_stop[e] = i_xwdata[STOP_BIT];
        case (flag_sel[e])
          FLAG_SEL_PROG:  selected_flag[e] = i_prog_flag[e];
          FLAG_SEL_EMPTY: selected_flag[e] = i_empty_flag[e];
          FLAG_SEL_FULL:  selected_flag[e] = i_full_flag[e];
          default:        selected_flag[e] = 1'b0;
        endcase
        next_watched_flag[e] = selected_flag[e];
        next_flag_stop[e]    = stop[e] && selected_flag[e];
        next_ep_start[e]     = (i_xwr && i_xaddr == TRIG_ADDR[e]) ||
                               (i_sfr_wr && i_sfr_addr == SFR_TRIGGER_ADDR &&
                                i_sfr_wdata[SFR_TRIG_LSB +: 2] == SFR_TRIG_CODE[e]);
      end

      always_ff @(posedge i_core_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          flag_sel[e]         <= FLAG_SEL_RESET;
          stop[e]             <= 1'b0;
          o_watched_flag[e]   <= 1'b0;
          o_flag_stop[e]      <= 1'b0;
          o_count_override[e] <= 1'b0;
          o_ep_start[e]       <= 1'b0;
        end
        else
        begin
          flag_sel[e]         <= next_flag_sel[e];
          stop[e]             <= next_stop[e];
          o_watched_flag[e]   <= next_watched_flag[e];
          o_flag_stop[e]      <= next_flag_stop[e];
          o_count_override[e] <= next_stop[e];
          o_ep_start[e]       <= next_ep_start[e];
        end
      end
    end
  endgenerate

  // Single transfer data. A processor write wins over a capture in the same cycle.
  always_comb
  begin
    next_data_high = data_high;
    next_data_low  = data_low;
    if (i_capture_valid)
    begin
      next_data_high = i_capture_data[15:8];
      next_data_low  = i_capture_data[7:0];
    end
    if (wr_hit(SINGLE_DATA_HIGH_ADDR))
      next_data_high = wr_data(SINGLE_DATA_HIGH_ADDR);
    if (wr_hit(SINGLE_DATA_LOW_TRIGGER_ADDR))
      next_data_low = wr_data(SINGLE_DATA_LOW_TRIGGER_ADDR);
    next_single_write_start = wr_hit(SINGLE_DATA_LOW_TRIGGER_ADDR);
    next_single_read_start  = rd_hit(SINGLE_DATA_LOW_TRIGGER_ADDR);
    next_single_wdata       = o_single_wdata;
    if (next_single_write_start)
      next_single_wdata = {(i_wide_bus ? next_data_high : 8'h00), next_data_low};
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      data_high            <= DATA_RESET;
      data_low             <= DATA_RESET;
      o_single_write_start <= 1'b0;
      o_single_read_start  <= 1'b0;
      o_single_wdata       <= 16'h0000;
    end
    else
    begin
      data_high            <= next_data_high;
      data_low             <= next_data_low;
      o_single_write_start <= next_single_write_start;
      o_single_read_start  <= next_single_read_start;
      o_single_wdata       <= next_single_wdata;
    end
  end

  wecr_ready_sync u_ready_sync
  (
    .i_core_clk    (i_core_clk),
    .i_rstn        (i_rstn),
    .i_ready_pins  (i_ready_inputs),
    .i_sync_select (ready_cfg[READY_SYNC_SELECT_BIT-READY_CFG_LSB]),
    .o_ready       (ready_synced)
  );

  // Ready configuration, abort strobe, ready terms and read data.
  always_comb
  begin
    next_ready_cfg = ready_cfg;
    if (i_xwr && i_xaddr == READY_INPUT_CONFIG_ADDR)
      next_ready_cfg = i_xwdata[7:READY_CFG_LSB];
    next_abort       = i_xwr && i_xaddr == WAVEFORM_ABORT_ADDR;
    next_ready_terms = {ready_cfg[FIRMWARE_READY_BIT-READY_CFG_LSB], ready_synced};
    next_xrdata      = i_xrd ? read_value(i_xaddr) : o_xrdata;
    next_sfr_rdata   = i_sfr_rd ? read_value(sfr_equiv) : o_sfr_rdata;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ready_cfg             <= READY_CFG_RESET;
      o_abort               <= 1'b0;
      o_ready_terms         <= '0;
      o_ready_sync_select   <= 1'b0;
      o_count_expiry_ready5 <= 1'b0;
      o_xrdata              <= UNMAPPED_READ;
      o_sfr_rdata           <= UNMAPPED_READ;
    end
    else
    begin
      ready_cfg             <= next_ready_cfg;
      o_abort               <= next_abort;
      o_ready_terms         <= next_ready_terms;
      o_ready_sync_select   <= next_ready_cfg[READY_SYNC_SELECT_BIT-READY_CFG_LSB];
      o_count_expiry_ready5 <= next_ready_cfg[COUNT_EXPIRY_READY5_BIT-READY_CFG_LSB];
      o_xrdata              <= next_xrdata;
      o_sfr_rdata           <= next_sfr_rdata;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  flag_sel_write_a: assert property ((i_xwr && i_xaddr == FLAG_SEL_ADDR[1]) |=>
    flag_sel[1] == $past(i_xwdata[1:0]))
    else $error("Flag select did not take written bits.");
  flag_sel_read_a: assert property ((i_xrd && i_xaddr == FLAG_SEL_ADDR[0]) |=>
    o_xrdata == {6'h00, $past(flag_sel[0])})
    else $error("Flag select read returned wrong value.");
  watched_empty_a: assert property ((flag_sel[2] == FLAG_SEL_EMPTY) |=>
    o_watched_flag[2] == $past(i_empty_flag[2]))
    else $error("Empty flag not watched when selected.");
  watched_full_a: assert property ((flag_sel[0] == FLAG_SEL_FULL) |=>
    o_watched_flag[0] == $past(i_full_flag[0]))
    else $error("Full flag not watched when selected.");
  flag_stop_a: assert property (o_flag_stop[0] |->
    $past(stop[0]) && $past(selected_flag[0]))
    else $error("Flag stop without enable and flag.");
  count_override_a: assert property ((i_xwr && i_xaddr == STOP_ADDR[1] && i_xwdata[0]) |=>
    o_count_override[1] && stop[1])
    else $error("Stop bit did not override count.");
  ep_trigger_a: assert property ((i_xwr && i_xaddr == TRIG_ADDR[2]) |=> o_ep_start[2])
    else $error("Trigger write did not start endpoint.");
  sfr_trigger_a: assert property ((i_sfr_wr && i_sfr_addr == SFR_TRIGGER_ADDR &&
    i_sfr_wdata[1:0] == 2'h1) |=> o_ep_start[0])
    else $error("Mirrored trigger did not start endpoint.");
  start_pulse_a: assert property ((o_ep_start[1] && !(i_xwr && i_xaddr == TRIG_ADDR[1]) &&
    !i_sfr_wr) |=> !o_ep_start[1])
    else $error("Endpoint start not a strobe.");
  abort_pulse_a: assert property ((i_xwr && i_xaddr == WAVEFORM_ABORT_ADDR) ##1
    !(i_xwr && i_xaddr == WAVEFORM_ABORT_ADDR) |-> o_abort ##1 !o_abort)
    else $error("Abort strobe wrong length.");
  single_write_a: assert property ((i_xwr && i_xaddr == SINGLE_DATA_LOW_TRIGGER_ADDR) |=>
    o_single_write_start && o_single_wdata[7:0] == $past(i_xwdata))
    else $error("Low trigger write did not launch transfer.");
  narrow_high_a: assert property ((i_xwr && i_xaddr == SINGLE_DATA_LOW_TRIGGER_ADDR &&
    !i_wide_bus) |=> o_single_wdata[15:8] == 8'h00)
    else $error("High byte driven on narrow bus.");
  quiet_read_a: assert property ((i_xrd && i_xaddr == SINGLE_DATA_LOW_QUIET_ADDR && !i_sfr_rd) |=>
    !o_single_read_start && o_xrdata == $past(data_low))
    else $error("Quiet low read wrong.");
  sfr_single_a: assert property ((i_sfr_rd && i_sfr_addr == SFR_SINGLE_DATA_LOW_TRIGGER_ADDR) |=>
    o_single_read_start && o_sfr_rdata == $past(data_low))
    else $error("Mirrored low trigger read wrong.");
  firmware_ready_a: assert property ((i_xwr && i_xaddr == READY_INPUT_CONFIG_ADDR) |=> ##1
    o_ready_terms[NUM_READY] == $past(i_xwdata[7], 2))
    else $error("Firmware ready not passed on.");
  async_ready_a: assert property ((!ready_cfg[1] && $past(i_rstn, 2)) |->
    ready_synced == $past(i_ready_inputs, 2))
    else $error("Asynchronous ready path not two flops.");
  ready_cfg_read_a: assert property ((i_xrd && i_xaddr == READY_INPUT_CONFIG_ADDR) |=>
    o_xrdata[4:0] == 5'h00 && o_xrdata[7:5] == $past(ready_cfg))
    else $error("Ready config read wrong.");
  ready_stat_a: assert property ((i_xrd && i_xaddr == READY_PIN_STATUS_ADDR) |=>
    o_xrdata == {2'h0, $past(ready_synced)})
    else $error("Ready status read wrong.");

  cover_trigger_c: cover property ((i_xwr && i_xaddr == TRIG_ADDR[0]) ##1 o_ep_start[0]);
  cover_flag_stop_c: cover property (o_count_override[2] ##[1:20] o_flag_stop[2]);
  cover_single_c: cover property (o_single_write_start ##[1:20] o_single_read_start);
  cover_abort_c: cover property (o_ep_start[1] ##[1:20] o_abort);

endmodule

// ===== bench/testbench.sv
// Self-checking testbench for the waveform engine control and status registers.
`timescale 1ns/100ps
module testbench;
  import wecr_pkg::*;
  logic                 i_core_clk, i_rstn, i_xwr, i_xrd, i_sfr_wr, i_sfr_rd;
  logic                 i_wide_bus, i_capture_valid;
  logic [15:0]          i_xaddr, i_capture_data;
  logic [7:0]           i_xwdata, i_sfr_addr, i_sfr_wdata, o_xrdata, o_sfr_rdata;
  logic [NUM_EP-1:0]    i_prog_flag, i_empty_flag, i_full_flag;
  logic [NUM_EP-1:0]    o_watched_flag, o_flag_stop, o_count_override, o_ep_start;
  logic [NUM_READY-1:0] i_ready_inputs;
  logic [NUM_READY:0]   o_ready_terms;
  logic                 o_single_write_start, o_single_read_start, o_abort;
  logic                 o_ready_sync_select, o_count_expiry_ready5;
  logic [15:0]          o_single_wdata;
  logic [2:0]           exp_w;
  int                   error_cnt, checks_done, cycles;

  wecr_regs u_wecr_regs (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_xaddr(i_xaddr), .i_xwr(i_xwr),
    .i_xrd(i_xrd), .i_xwdata(i_xwdata), .o_xrdata(o_xrdata), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_prog_flag(i_prog_flag), .i_empty_flag(i_empty_flag),
    .i_full_flag(i_full_flag), .i_wide_bus(i_wide_bus), .i_capture_valid(i_capture_valid),
    .i_capture_data(i_capture_data), .i_ready_inputs(i_ready_inputs),
    .o_watched_flag(o_watched_flag), .o_flag_stop(o_flag_stop),
    .o_count_override(o_count_override), .o_ep_start(o_ep_start),
    .o_single_write_start(o_single_write_start), .o_single_read_start(o_single_read_start),
    .o_single_wdata(o_single_wdata), .o_abort(o_abort), .o_ready_terms(o_ready_terms),
    .o_ready_sync_select(o_ready_sync_select), .o_count_expiry_ready5(o_count_expiry_ready5)
  );

  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic close_out();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // A hung sequence is cut short well beyond the fewer than two hundred cycles the tests need.
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      close_out();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_xaddr  = a;
    i_xwdata = d;
    i_xwr    = 1'b1;
    @(negedge i_core_clk);
    i_xwr = 1'b0;
  endtask

  task automatic xr(input logic [15:0] a, input logic [7:0] exp);
    @(negedge i_core_clk);
    i_xaddr = a;
    i_xrd   = 1'b1;
    @(negedge i_core_clk);
    i_xrd = 1'b0;
    cmp({8'h00, o_xrdata}, {8'h00, exp}, "data read");
  endtask

  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_sfr_addr  = a;
    i_sfr_wdata = d;
    i_sfr_wr    = 1'b1;
    @(negedge i_core_clk);
    i_sfr_wr = 1'b0;
  endtask

  task automatic sr(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_core_clk);
    i_sfr_addr = a;
    i_sfr_rd   = 1'b1;
    @(negedge i_core_clk);
    i_sfr_rd = 1'b0;
    cmp({8'h00, o_sfr_rdata}, {8'h00, exp}, "sfr read");
  endtask

  // Drives new pins and checks that the conditioned copy appears after exactly lat edges.
  task automatic ready_lat(input logic [5:0] pins, input int lat);
    i_ready_inputs = pins;
    repeat (lat - 1) @(negedge i_core_clk);
    cmp({10'h000, o_ready_terms[5:0]}, {10'h000, ~pins}, "ready early");
    @(negedge i_core_clk);
    cmp({10'h000, o_ready_terms[5:0]}, {10'h000, pins}, "ready latency");
  endtask

  initial
  begin
    {i_rstn, i_xwr, i_xrd, i_sfr_wr, i_sfr_rd, i_wide_bus, i_capture_valid} = '0;
    {i_xaddr, i_capture_data, i_xwdata, i_sfr_addr, i_sfr_wdata} = '0;
    i_prog_flag    = 3'h1;
    i_empty_flag   = 3'h2;
    i_full_flag    = 3'h4;
    i_ready_inputs = 6'h00;
    repeat (3) @(negedge i_core_clk);
    i_rstn = 1'b1;
    for (int e = 0; e < NUM_EP; e++)
    begin
      xr(FLAG_SEL_ADDR[e], 8'h00);
      xr(STOP_ADDR[e], 8'h00);
      xw(FLAG_SEL_ADDR[e], 8'hff);
      xr(FLAG_SEL_ADDR[e], 8'h03);
      xw(STOP_ADDR[e], 8'hff);
      xr(STOP_ADDR[e], 8'h01);
    end
    xr(READY_INPUT_CONFIG_ADDR, 8'h00);
    cmp({13'h0000, o_count_override}, 16'h0007, "count override");
    for (int c = 0; c < 4; c++)
    begin
      for (int e = 0; e < NUM_EP; e++)
        xw(FLAG_SEL_ADDR[e], 8'(c));
      @(negedge i_core_clk);
      exp_w = (c == 0) ? 3'h1 : (c == 1) ? 3'h2 : (c == 2) ? 3'h4 : 3'h0;
      cmp({13'h0000, o_watched_flag}, {13'h0000, exp_w}, "watched flag");
      cmp({13'h0000, o_flag_stop}, {13'h0000, exp_w}, "flag stop");
    end
    xw(FLAG_SEL_ADDR[0], 8'h00);
    xw(STOP_ADDR[0], 8'h00);
    @(negedge i_core_clk);
    cmp({13'h0000, o_watched_flag}, 16'h0001, "watched without stop");
    cmp({13'h0000, o_flag_stop}, 16'h0000, "flag stop disabled");
    cmp({13'h0000, o_count_override}, 16'h0006, "count override off");
    for (int e = 0; e < NUM_EP; e++)
    begin
      xw(TRIG_ADDR[e], 8'h5a);
      cmp({13'h0000, o_ep_start}, 16'(1 << e), "trigger pulse");
      @(negedge i_core_clk);
      cmp({13'h0000, o_ep_start}, 16'h0000, "trigger one cycle");
      sw(SFR_TRIGGER_ADDR, {6'h00, SFR_TRIG_CODE[e]});
      cmp({13'h0000, o_ep_start}, 16'(1 << e), "sfr trigger pulse");
      xr(TRIG_ADDR[e], WRITE_ONLY_READ);
    end
    sw(SFR_TRIGGER_ADDR, 8'h00);
    cmp({13'h0000, o_ep_start}, 16'h0000, "sfr trigger code zero");
    xw(WAVEFORM_ABORT_ADDR, 8'hc3);
    cmp({15'h0000, o_abort}, 16'h0001, "abort pulse");
    @(negedge i_core_clk);
    cmp({15'h0000, o_abort}, 16'h0000, "abort one cycle");
    xr(WAVEFORM_ABORT_ADDR, WRITE_ONLY_READ);
    xw(16'he6f6, 8'hff);
    xr(16'he6f6, UNMAPPED_READ);
    i_wide_bus = 1'b1;
    xw(SINGLE_DATA_HIGH_ADDR, 8'haa);
    xr(SINGLE_DATA_HIGH_ADDR, 8'haa);
    xw(SINGLE_DATA_LOW_TRIGGER_ADDR, 8'h55);
    cmp({15'h0000, o_single_write_start}, 16'h0001, "single write");
    cmp(o_single_wdata, 16'haa55, "wide single data");
    i_wide_bus = 1'b0;
    xw(SINGLE_DATA_LOW_TRIGGER_ADDR, 8'h66);
    cmp(o_single_wdata, 16'h0066, "narrow single data");
    sw(SFR_SINGLE_DATA_HIGH_ADDR, 8'h12);
    xr(SINGLE_DATA_HIGH_ADDR, 8'h12);
    sr(SFR_SINGLE_DATA_HIGH_ADDR, 8'h12);
    i_wide_bus = 1'b1;
    sw(SFR_SINGLE_DATA_LOW_TRIGGER_ADDR, 8'h34);
    cmp({15'h0000, o_single_write_start}, 16'h0001, "sfr single write");
    cmp(o_single_wdata, 16'h1234, "sfr single data");
    @(negedge i_core_clk);
    i_capture_data  = 16'hbeef;
    i_capture_valid = 1'b1;
    @(negedge i_core_clk);
    i_capture_valid = 1'b0;
    xr(SINGLE_DATA_LOW_QUIET_ADDR, 8'hef);
    cmp({15'h0000, o_single_read_start}, 16'h0000, "quiet read no start");
    sr(SFR_SINGLE_DATA_LOW_QUIET_ADDR, 8'hef);
    xr(SINGLE_DATA_LOW_TRIGGER_ADDR, 8'hef);
    cmp({15'h0000, o_single_read_start}, 16'h0001, "single read start");
    sr(SFR_SINGLE_DATA_LOW_TRIGGER_ADDR, 8'hef);
    cmp({15'h0000, o_single_read_start}, 16'h0001, "sfr single read start");
    xw(SINGLE_DATA_LOW_QUIET_ADDR, 8'h00);
    xr(SINGLE_DATA_LOW_QUIET_ADDR, 8'hef);
    i_ready_inputs = 6'h15;
    repeat (4) @(negedge i_core_clk);
    ready_lat(6'h2a, 3);
    xr(READY_PIN_STATUS_ADDR, 8'h2a);
    xw(READY_PIN_STATUS_ADDR, 8'hff);
    xr(READY_PIN_STATUS_ADDR, 8'h2a);
    xw(READY_INPUT_CONFIG_ADDR, 8'hff);
    xr(READY_INPUT_CONFIG_ADDR, 8'he0);
    cmp({14'h0000, o_ready_sync_select, o_count_expiry_ready5}, 16'h0003, "cfg");
    cmp({15'h0000, o_ready_terms[6]}, 16'h0001, "firmware ready");
    ready_lat(6'h15, 2);
    xw(READY_INPUT_CONFIG_ADDR, 8'h00);
    repeat (2) @(negedge i_core_clk);
    cmp({15'h0000, o_ready_terms[6]}, 16'h0000, "firmware ready off");
    close_out();
  end
endmodule
